// >>> pfri_pkg.sv
// Package of constants and types for the PWM fault/retrigger input block
package pfri_pkg;

  // Bus and channel widths
  localparam int NCH    = 2;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL_A   = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_CTRL_B   = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_RUN      = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 3'h5;

  // Field positions of input_channel_ctrl
  localparam int CTL_MODE_LSB = 0;
  localparam int CTL_MODE_W   = 4;
  localparam int CTL_POL_BIT  = 4;
  localparam int CTL_FLT_BIT  = 5;
  localparam int CTL_AOC_BIT  = 6;
  localparam int CTL_SRC_BIT  = 7;

  // Reset values
  localparam logic [DATA_W-1:0] CTRL_RST = 8'h00;
  localparam logic [1:0]        RUN_RST  = 2'h0;
  localparam logic [NCH-1:0]    MASK_RST = 2'h0;

  // Noise filter length in pwm_core_clock cycles
  localparam int       FILT_CYC  = 4;
  localparam logic [2:0] FILT_LAST = 3'(FILT_CYC - 1);

  // input_mode_sel codes handled here
  localparam logic [3:0] IM_NONE      = 4'h0;
  localparam logic [3:0] IM_STOP_WAIT = 4'h1;
  localparam logic [3:0] IM_STOP_EXEC = 4'h2;
  localparam logic [3:0] IM_STOP_RPT  = 4'h3;
  localparam logic [3:0] IM_RETRIG    = 4'h8;

  // Running modes
  localparam logic [1:0] RM_ONE    = 2'h0;
  localparam logic [1:0] RM_TWO    = 2'h1;
  localparam logic [1:0] RM_FOUR   = 2'h2;
  localparam logic [1:0] RM_CENTER = 2'h3;

  // Sub-cycle phase from the counter core
  localparam logic [1:0] PH_DT0 = 2'h0;
  localparam logic [1:0] PH_OT0 = 2'h1;
  localparam logic [1:0] PH_DT1 = 2'h2;
  localparam logic [1:0] PH_OT1 = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_OPP  = 2'b10,
    ST_HOLD = 2'b11
  } pfri_chst_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } pfri_bus_req_s;

  typedef struct packed {
    logic [NCH-1:0] out_release;
    logic [NCH-1:0] sub_hold;
    logic [NCH-1:0] jump_opp;
    logic           cnt_clr;
  } pfri_core_ctl_s;

  typedef struct packed {
    logic [2:0] sync;
    logic       filt;
    logic [2:0] fcnt;
    logic       act_q;
    pfri_chst_e st;
    logic       release_q;
    logic       hold_q;
    logic       jump_q;
  } pfri_ch_s;

  typedef struct packed {
    pfri_ch_s [NCH-1:0]              ch;
    logic [NCH-1:0][DATA_W-1:0]      ctrl;
    logic [1:0]                      run;
    logic [1:0]                      phase_q;
    logic [NCH-1:0]                  irq_stat;
    logic [NCH-1:0]                  irq_mask;
    logic                            clr_q;
    logic [DATA_W-1:0]               rdata;
  } pfri_state_s;

  localparam pfri_state_s STATE_RST = '{
    ch:       '0,
    ctrl:     {CTRL_RST, CTRL_RST},
    run:      RUN_RST,
    phase_q:  PH_DT0,
    irq_stat: '0,
    irq_mask: MASK_RST,
    clr_q:    1'b0,
    rdata:    '0
  };

endpackage

// >>> pfri_input.sv
// Two-channel fault and retrigger input processing for the PWM controller
// Function
// RULE_01: Two channels A and B, each with its own control register.
// RULE_02: Centered running mode ignores retrigger events on both channels.
// RULE_03: Two/four-ramp retrigger ends own cycle, starts opposite cycle at once.
// RULE_04: One-ramp retrigger on either channel clears the PWM counter.
// RULE_05: Channel A releases first output; mode and source are selectable.
// RULE_06: Channel B releases second output; polarity, mode, source selectable.
// RULE_07: Filter-enable inserts a four-cycle noise filter, else bypassed.
// RULE_08: Async kill forces outputs off without clock; normal processing continues.
// RULE_09: Polarity set means rising/high active, clear means falling/low.
// RULE_10: Multi-ramp: A evaluated in DT0/OT0, B in DT1/OT1 only.
// RULE_11: One-ramp: both channels evaluated over the whole ramp.
// RULE_12: Four-bit mode field; 0 no effect, reserved codes not programmed.
// RULE_13: Mode 1 A: release first, wait inactive, then DT1 and OT1.
// RULE_14: Mode 1 B: release second, wait inactive, then DT0 and OT0.
// RULE_15: Mode 2 A: release first, full DT1+OT1, then wait inactive.
// RULE_16: Mode 2 B: release second, full DT0+OT0, then wait inactive.
// RULE_17: Mode 3 A: repeat DT1, OT1, DT0 while active; sub-cycles complete.
// RULE_18: Mode 3 B: repeat DT0, OT0, DT1 while active; sub-cycles complete.
// RULE_19: Reserved or external-block modes take no action on outputs.
`timescale 1ns/10ps
module pfri_input
  import pfri_pkg::*;
(
  // Clock and reset
  input  wire logic           sys_clk_i,
  input  wire logic           rstn_i,
  // Register port
  input  wire pfri_bus_req_s  bus_i,
  output logic [DATA_W-1:0]   rdata_o,
  // Fault and retrigger sources
  input  wire logic [NCH-1:0] ext_trigger_pin_i,
  input  wire logic [NCH-1:0] cmp_out_i,
  // Counter core
  input  wire logic [1:0]     phase_i,
  output pfri_core_ctl_s      core_ctl_o,
  output logic [NCH-1:0]      async_output_kill_o,
  // Interrupt
  output logic                irq_o
);

  pfri_state_s s;
  pfri_state_s next_s;

  logic [NCH-1:0] pol;
  logic [NCH-1:0] fen;
  logic [NCH-1:0] aoc;
  logic [NCH-1:0] src_raw;
  logic [NCH-1:0] agree;
  logic [NCH-1:0] cand;
  logic [NCH-1:0] act;
  logic [NCH-1:0] own;
  logic [NCH-1:0] win;
  logic [NCH-1:0] fault_ok;
  logic [NCH-1:0] retrig_ok;
  logic [NCH-1:0] edge_evt;
  logic [NCH-1:0] ot_entry;
  logic [NCH-1:0][3:0] mode;
  logic           one_ramp;
  logic           multi;

  // Phases belonging to a channel's own sub-cycle
  function automatic logic own_phase(input int ch, input logic [1:0] ph);
    if (ch == 0) begin
      return (ph == PH_DT0) || (ph == PH_OT0);
    end
    return (ph == PH_DT1) || (ph == PH_OT1);
  endfunction

  // Fault modes 1..3 only where the running mode supports them
  function automatic logic fault_allowed(input logic [3:0] m, input logic [1:0] rm);
    logic ml;
    ml = (rm == RM_TWO) || (rm == RM_FOUR);
    case (m)
      IM_STOP_WAIT: return rm != RM_CENTER;
      IM_STOP_EXEC,
      IM_STOP_RPT:  return ml;
      default:      return 1'b0; // RULE_19
    endcase
  endfunction

  assign one_ramp = (s.run == RM_ONE);                     // RULE_11
  assign multi    = (s.run == RM_TWO) || (s.run == RM_FOUR);

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      assign mode[gi] = s.ctrl[gi][CTL_MODE_LSB +: CTL_MODE_W]; // RULE_01
      assign pol[gi]  = s.ctrl[gi][CTL_POL_BIT];
      assign fen[gi]  = s.ctrl[gi][CTL_FLT_BIT];
      assign aoc[gi]  = s.ctrl[gi][CTL_AOC_BIT];
      // Source select is quasi-static, so muxing before the synchroniser is safe
      assign src_raw[gi] = s.ctrl[gi][CTL_SRC_BIT] ? cmp_out_i[gi] : ext_trigger_pin_i[gi];
      // Emergency path: no clock needed, so it stays combinational
      assign async_output_kill_o[gi] = aoc[gi] & (src_raw[gi] == pol[gi]); // RULE_08
      assign agree[gi] = (s.ch[gi].sync[1] == s.ch[gi].sync[2]);
      assign cand[gi]  = agree[gi] & (s.ch[gi].sync[2] != s.ch[gi].filt);
      assign act[gi]   = (s.ch[gi].filt == pol[gi]);              // RULE_09
      assign own[gi]   = own_phase(gi, phase_i);
      assign win[gi]   = one_ramp | (multi & own[gi]);            // RULE_10
      assign fault_ok[gi]  = fault_allowed(mode[gi], s.run);      // RULE_12
      assign retrig_ok[gi] = (mode[gi] == IM_RETRIG) && (s.run != RM_CENTER); // RULE_02
      assign edge_evt[gi]  = act[gi] & ~s.ch[gi].act_q;
      assign ot_entry[gi]  = own_phase(gi, s.phase_q) && !own_phase(gi, phase_i) ? 1'b0 :
                             ((phase_i == (gi == 0 ? PH_OT0 : PH_OT1)) &&
                              (s.phase_q == (gi == 0 ? PH_DT0 : PH_DT1)));
    end
  endgenerate

  always_comb begin
    logic [NCH-1:0] fire;
    logic [NCH-1:0] evt;
    fire   = '0;
    evt    = '0;
    next_s = s;
    next_s.rdata   = '0;
    next_s.phase_q = phase_i;
    next_s.clr_q   = 1'b0;

    for (int i = 0; i < NCH; i++) begin
      // First stage only feeds the second
      next_s.ch[i].sync   = {s.ch[i].sync[1:0], src_raw[i]};
      next_s.ch[i].act_q  = act[i];
      next_s.ch[i].jump_q = 1'b0;

      // Filter trades latency for noise immunity; bypass for slow clocks
      if (fen[i]) begin
        if (cand[i]) begin
          if (s.ch[i].fcnt == FILT_LAST) begin
            next_s.ch[i].filt = s.ch[i].sync[2];                  // RULE_07
            next_s.ch[i].fcnt = '0;
          end else begin
            next_s.ch[i].fcnt = s.ch[i].fcnt + 3'h1;
          end
        end else begin
          next_s.ch[i].fcnt = '0;
        end
      end else begin
        next_s.ch[i].fcnt = '0;
        if (agree[i]) begin
          next_s.ch[i].filt = s.ch[i].sync[2];                    // RULE_07
        end
      end

      case (s.ch[i].st)
        ST_IDLE: begin
          if (fault_ok[i] && win[i] && act[i]) begin
            evt[i] = 1'b1;
            if (mode[i] == IM_STOP_WAIT) begin
              next_s.ch[i].st = ST_WAIT;                          // RULE_13 RULE_14
            end else begin
              fire[i] = 1'b1;                                     // RULE_15 RULE_16
              next_s.ch[i].st = ST_OPP;
            end
          end else if (retrig_ok[i] && win[i] && edge_evt[i]) begin
            evt[i]  = 1'b1;
            fire[i] = 1'b1;                                       // RULE_03 RULE_04
          end
        end
        ST_WAIT: begin
          if (!fault_ok[i]) begin
            next_s.ch[i].st = ST_IDLE;                            // RULE_19
          end else if (!act[i]) begin
            fire[i] = 1'b1;                                       // RULE_13 RULE_14
            next_s.ch[i].st = ST_IDLE;
          end
        end
        ST_OPP: begin
          if (!fault_ok[i]) begin
            next_s.ch[i].st = ST_IDLE;
          end else if (own[i] && !s.ch[i].jump_q) begin
            // Core moves one edge after the jump pulse, so skip that cycle
            // Opposite sub-cycle has fully run before own phases return
            if (!act[i]) begin
              next_s.ch[i].st = ST_IDLE;                          // RULE_15 RULE_16
            end else if (mode[i] == IM_STOP_EXEC) begin
              next_s.ch[i].st = ST_HOLD;                          // RULE_15 RULE_16
            end else if (ot_entry[i]) begin
              fire[i] = 1'b1;                                     // RULE_17 RULE_18
            end
          end
        end
        ST_HOLD: begin
          if (!fault_ok[i] || !act[i]) begin
            next_s.ch[i].st = ST_IDLE;
          end
        end
        default: begin
          next_s.ch[i].st = ST_IDLE;
        end
      endcase

      if (fire[i]) begin
        if (one_ramp) begin
          next_s.clr_q = 1'b1;                                    // RULE_04
        end else if (multi) begin
          next_s.ch[i].jump_q = 1'b1;                             // RULE_03
        end
      end
      // Release first/second output while the channel holds a fault
      next_s.ch[i].release_q = (next_s.ch[i].st != ST_IDLE);      // RULE_05 RULE_06
      next_s.ch[i].hold_q    = (next_s.ch[i].st == ST_WAIT) ||
                               (next_s.ch[i].st == ST_HOLD);
    end

    // Register writes
    if (bus_i.wr) begin
      case (bus_i.addr)
        OFS_CTRL_A:   next_s.ctrl[0]  = bus_i.wdata;
        OFS_CTRL_B:   next_s.ctrl[1]  = bus_i.wdata;
        OFS_RUN:      next_s.run      = bus_i.wdata[1:0];
        OFS_IRQ_MASK: next_s.irq_mask = bus_i.wdata[NCH-1:0];
        default:      next_s.run      = s.run;
      endcase
    end

    // Reads; a set in the clearing cycle survives
    next_s.irq_stat = s.irq_stat | evt;
    if (bus_i.rd) begin
      case (bus_i.addr)
        OFS_CTRL_A:   next_s.rdata = s.ctrl[0];
        OFS_CTRL_B:   next_s.rdata = s.ctrl[1];
        OFS_RUN:      next_s.rdata = {6'h00, s.run};
        OFS_IRQ_STAT: begin
          next_s.rdata    = {6'h00, s.irq_stat};
          next_s.irq_stat = evt;
        end
        OFS_IRQ_MASK: next_s.rdata = {6'h00, s.irq_mask};
        OFS_STATUS:   next_s.rdata = {2'h0, s.ch[1].hold_q, s.ch[0].hold_q,
                                      s.ch[1].release_q, s.ch[0].release_q, act};
        default:      next_s.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      s <= STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  assign rdata_o = s.rdata;
  assign irq_o   = |(s.irq_stat & s.irq_mask);
  assign core_ctl_o.out_release = {s.ch[1].release_q, s.ch[0].release_q};
  assign core_ctl_o.sub_hold    = {s.ch[1].hold_q, s.ch[0].hold_q};
  assign core_ctl_o.jump_opp    = {s.ch[1].jump_q, s.ch[0].jump_q};
  assign core_ctl_o.cnt_clr     = s.clr_q;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  a_center_no_retrig: assert property ( // RULE_02
    (s.run == RM_CENTER && !(bus_i.wr && bus_i.addr == OFS_RUN)) |=>
      (core_ctl_o.jump_opp == '0 && !core_ctl_o.cnt_clr))
    else $error("retrigger action in centered mode");

  a_jump_multi_only: assert property ( // RULE_03
    (core_ctl_o.jump_opp != '0) |-> ($past(multi) && !core_ctl_o.cnt_clr))
    else $error("jump outside two or four ramp mode");

  a_clear_one_ramp: assert property ( // RULE_04
    core_ctl_o.cnt_clr |-> $past(one_ramp))
    else $error("counter clear outside one ramp mode");

  a_filter_four: assert property ( // RULE_07
    ($past(fen[0]) && $changed(s.ch[0].filt)) |->
      ($past(cand[0], 1) && $past(cand[0], 2) && $past(cand[0], 3) && $past(cand[0], 4)))
    else $error("filter changed before four stable cycles");

  a_async_kill: assert property ( // RULE_08
    (aoc[1] && src_raw[1] == pol[1]) |-> async_output_kill_o[1])
    else $error("async kill not asserted");

  a_window_a: assert property ( // RULE_10
    ($rose(core_ctl_o.out_release[0]) && $past(multi)) |-> $past(own[0]))
    else $error("channel A acted outside its phases");

  a_window_b: assert property ( // RULE_10
    ($rose(core_ctl_o.out_release[1]) && $past(multi)) |-> $past(own[1]))
    else $error("channel B acted outside its phases");

  a_mode1_wait: assert property ( // RULE_13
    (s.ch[0].st == ST_WAIT && act[0] && fault_ok[0]) |=>
      (core_ctl_o.sub_hold[0] && core_ctl_o.out_release[0] && !core_ctl_o.jump_opp[0]))
    else $error("mode 1 did not hold while input active");

  a_mode2_full: assert property ( // RULE_16
    (s.ch[1].st == ST_OPP && !own[1] && fault_ok[1]) |=> core_ctl_o.out_release[1])
    else $error("mode 2 opposite sub-cycle cut short");

  a_reserved_idle: assert property ( // RULE_19
    (s.ch[0].st == ST_IDLE && !fault_ok[0] && mode[0] != IM_RETRIG) |=>
      (!core_ctl_o.out_release[0] && !core_ctl_o.jump_opp[0]))
    else $error("reserved mode acted on outputs");

  a_irq_level: assert property (
    (($past(s.irq_stat & s.irq_mask) != '0) && !$past(bus_i.rd) && !$past(bus_i.wr)) |->
      irq_o)
    else $error("interrupt dropped without a read");

  a_release_a: assert property ( // RULE_05
    $rose(core_ctl_o.out_release[0]) |-> $past(fault_ok[0] && act[0] && win[0]))
    else $error("first output released without a fault");

  a_release_b: assert property ( // RULE_06
    $rose(core_ctl_o.out_release[1]) |-> $past(fault_ok[1] && act[1] && win[1]))
    else $error("second output released without a fault");

  a_one_ramp_win: assert property ( // RULE_11
    (one_ramp && s.ch[1].st == ST_IDLE && retrig_ok[1] && edge_evt[1]) |=>
      core_ctl_o.cnt_clr)
    else $error("one ramp retrigger missed");

  a_mode1_resume: assert property ( // RULE_13
    (s.ch[0].st == ST_WAIT && fault_ok[0] && !act[0] && multi) |=>
      (core_ctl_o.jump_opp[0] && !core_ctl_o.out_release[0]))
    else $error("mode 1 channel A did not jump after input cleared");

  a_mode1_wait_b: assert property ( // RULE_14
    (s.ch[1].st == ST_WAIT && act[1] && fault_ok[1]) |=>
      (core_ctl_o.sub_hold[1] && core_ctl_o.out_release[1] && !core_ctl_o.jump_opp[1]))
    else $error("mode 1 channel B did not hold while input active");

  a_mode1_resume_b: assert property ( // RULE_14
    (s.ch[1].st == ST_WAIT && fault_ok[1] && !act[1] && multi) |=>
      (core_ctl_o.jump_opp[1] && !core_ctl_o.out_release[1]))
    else $error("mode 1 channel B did not jump after input cleared");

  a_mode2_full_a: assert property ( // RULE_15
    (s.ch[0].st == ST_OPP && !own[0] && fault_ok[0]) |=> core_ctl_o.out_release[0])
    else $error("mode 2 channel A opposite sub-cycle cut short");

  a_mode2_hold_a: assert property ( // RULE_15
    (s.ch[0].st == ST_OPP && mode[0] == IM_STOP_EXEC && fault_ok[0] && own[0] &&
     !s.ch[0].jump_q && act[0]) |=>
      (core_ctl_o.sub_hold[0] && core_ctl_o.out_release[0]))
    else $error("mode 2 channel A did not wait for input inactive");

  a_mode2_hold_b: assert property ( // RULE_16
    (s.ch[1].st == ST_OPP && mode[1] == IM_STOP_EXEC && fault_ok[1] && own[1] &&
     !s.ch[1].jump_q && act[1]) |=>
      (core_ctl_o.sub_hold[1] && core_ctl_o.out_release[1]))
    else $error("mode 2 channel B did not wait for input inactive");

  a_mode3_repeat_a: assert property ( // RULE_17
    (s.ch[0].st == ST_OPP && mode[0] == IM_STOP_RPT && fault_ok[0] && act[0] &&
     ot_entry[0] && !s.ch[0].jump_q) |=>
      core_ctl_o.jump_opp[0])
    else $error("mode 3 channel A did not repeat the opposite sub-cycle");

  a_mode3_repeat_b: assert property ( // RULE_18
    (s.ch[1].st == ST_OPP && mode[1] == IM_STOP_RPT && fault_ok[1] && act[1] &&
     ot_entry[1] && !s.ch[1].jump_q) |=>
      core_ctl_o.jump_opp[1])
    else $error("mode 3 channel B did not repeat the opposite sub-cycle");

  a_mode3_stop_a: assert property ( // RULE_17
    (s.ch[0].st == ST_OPP && mode[0] == IM_STOP_RPT && fault_ok[0] && own[0] &&
     !s.ch[0].jump_q && !act[0]) |=> !core_ctl_o.out_release[0])
    else $error("mode 3 channel A kept output released after input cleared");

  a_mode3_stop_b: assert property ( // RULE_18
    (s.ch[1].st == ST_OPP && mode[1] == IM_STOP_RPT && fault_ok[1] && own[1] &&
     !s.ch[1].jump_q && !act[1]) |=> !core_ctl_o.out_release[1])
    else $error("mode 3 channel B kept output released after input cleared");

  a_rdata_idle: assert property (
    !$past(bus_i.rd) |-> (rdata_o == '0))
    else $error("read data outside the answer cycle");

  a_kill_off_a: assert property ( // RULE_08
    !aoc[0] |-> !async_output_kill_o[0])
    else $error("async kill without its enable");

endmodule

// >>> pfri_src_model.sv
// Fault sources and counter core model facing the input block
`timescale 1ns/10ps
module pfri_src_model
  import pfri_pkg::*;
#(
  parameter int PH_LEN = 8
)
(
  // Clock and reset
  input  wire logic           sys_clk_i,
  input  wire logic           rstn_i,
  // Requested fault state, true when active
  input  wire logic [NCH-1:0] fault_i,
  input  wire logic [NCH-1:0] pol_i,
  input  wire logic [NCH-1:0] src_cmp_i,
  // Counter core side
  input  wire pfri_core_ctl_s core_ctl_i,
  output logic [NCH-1:0]      pin_o,
  output logic [NCH-1:0]      cmp_o,
  output logic [1:0]          phase_o
);
  logic [3:0] cnt;
  logic       noise;

  // Unused source toggles so a wrong source select shows up
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      pin_o[i] = src_cmp_i[i] ? noise : ~(fault_i[i] ^ pol_i[i]);
      cmp_o[i] = src_cmp_i[i] ? ~(fault_i[i] ^ pol_i[i]) : noise;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    noise <= rstn_i ? ~noise : 1'b0;
    if (!rstn_i || core_ctl_i.cnt_clr) begin
      cnt <= '0;
      phase_o <= PH_DT0;
    end else if (core_ctl_i.jump_opp[0]) begin
      cnt <= '0;
      phase_o <= PH_DT1;
    end else if (core_ctl_i.jump_opp[1]) begin
      cnt <= '0;
      phase_o <= PH_DT0;
    end else if (core_ctl_i.sub_hold == '0) begin
      cnt <= (cnt == 4'(PH_LEN - 1)) ? 4'h0 : cnt + 4'h1;
      if (cnt == 4'(PH_LEN - 1)) begin
        phase_o <= phase_o + 2'h1;
      end
    end
  end
endmodule

// >>> tb_pfri_input.sv
// Self-checking bench for the fault and retrigger input block
`timescale 1ns/10ps
module tb_pfri_input
  import pfri_pkg::*;
;
  logic           clk;
  logic           rstn;
  pfri_bus_req_s  bus;
  logic [7:0]     rdata;
  logic [1:0]     fault, pol, srcc, pin, cmp, phase, kill;
  pfri_core_ctl_s ctl;
  logic           irq;
  int             failures, total_checks, jmp_cnt, clr_cnt, rel_cnt, j0, k0;
  logic [7:0]     r;

  pfri_input dut (.sys_clk_i(clk), .rstn_i(rstn), .bus_i(bus), .rdata_o(rdata),
    .ext_trigger_pin_i(pin), .cmp_out_i(cmp), .phase_i(phase), .core_ctl_o(ctl),
    .async_output_kill_o(kill), .irq_o(irq));
  pfri_src_model src (.sys_clk_i(clk), .rstn_i(rstn), .fault_i(fault), .pol_i(pol),
    .src_cmp_i(srcc), .core_ctl_i(ctl), .pin_o(pin), .cmp_o(cmp), .phase_o(phase));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    jmp_cnt <= jmp_cnt + int'(ctl.jump_opp[0]) + int'(ctl.jump_opp[1]);
    clr_cnt <= clr_cnt + int'(ctl.cnt_clr);
    rel_cnt <= rel_cnt + int'(|ctl.out_release);
  end

  function automatic logic [7:0] cfg(input int ch, input logic [3:0] m, input logic f, a);
    return {ch == 1, a, f, ch == 0, m};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] exp, input logic [7:0] msk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    @(negedge clk);
    chk(rdata & msk, exp);
    @(posedge clk);
  endtask

  task automatic setch(input int ch, input logic [3:0] m, input logic f, a);
    pol[ch] <= (ch == 0);
    srcc[ch] <= (ch == 1);
    wr(OFS_CTRL_A + 3'(ch), cfg(ch, m, f, a));
  endtask

  task automatic wt(input int sel, input int ch, input logic v, input int lim);
    int n;
    n = 0;
    while ((sel == 0 ? ctl.out_release[ch] : ctl.sub_hold[ch]) !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk(8'(sel == 0 ? ctl.out_release[ch] : ctl.sub_hold[ch]), 8'(v));
    @(posedge clk);
  endtask

  task automatic wait_ph(input logic [1:0] p);
    int n;
    n = 0;
    while (phase !== p - 2'h1 && n < 64) begin
      @(negedge clk);
      n++;
    end
    while (phase !== p && n < 128) begin
      @(negedge clk);
      n++;
    end
    chk(8'(phase), 8'(p));
    @(posedge clk);
  endtask

  task automatic pulse(input int ch, input int n);
    fault[ch] <= 1'b1;
    repeat (n) @(posedge clk);
    fault[ch] <= 1'b0;
    repeat (14) @(posedge clk);
  endtask

  task automatic fault_seq(input int ch, input logic [3:0] m);
    setch(ch, m, 1'b0, 1'b0);
    j0 = jmp_cnt;
    wait_ph(ch == 0 ? PH_DT0 : PH_DT1);
    fault[ch] <= 1'b1;
    wt(0, ch, 1'b1, 12);
    if (m == IM_STOP_WAIT) begin
      wt(1, ch, 1'b1, 2);
      repeat (20) @(posedge clk);
    end else begin
      wt(1, ch, 1'b1, 40);
    end
    chk(8'(jmp_cnt - j0), m == IM_STOP_WAIT ? 8'h00 : 8'h01);
    chk(8'(ctl.out_release[ch]), 8'h01);
    fault[ch] <= 1'b0;
    wt(0, ch, 1'b0, 12);
    @(posedge clk);
    chk(8'(jmp_cnt - j0), 8'h01);
  endtask

  task automatic results;
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    results();
  end

  initial begin
    rstn = 1'b0;
    bus = '0;
    fault = 2'b00;
    pol = 2'b00;
    srcc = 2'b00;
    void'($urandom(70));
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), 8'h00, 8'hff);
    end
    setch(0, IM_NONE, 1'b0, 1'b0);
    r = 8'($urandom);
    setch(1, IM_NONE, r[5], r[6]);
    rd(OFS_CTRL_B, cfg(1, IM_NONE, r[5], r[6]), 8'hff);
    rd(OFS_CTRL_A, 8'h10, 8'hff);
    wr(OFS_RUN, 8'h01);
    rd(OFS_RUN, 8'h01, 8'hff);
    rd(OFS_IRQ_STAT, 8'h00, 8'hff);
    wr(OFS_IRQ_MASK, r);
    rd(OFS_IRQ_MASK, r & 8'h03, 8'hff);
    wr(OFS_IRQ_MASK, 8'h02);
    fault_seq(0, IM_STOP_WAIT);
    chk(8'(irq), 8'h00);
    fault_seq(1, IM_STOP_WAIT);
    chk(8'(irq), 8'h01);
    rd(OFS_IRQ_STAT, 8'h03, 8'hff);
    chk(8'(irq), 8'h00);
    fault_seq(0, IM_STOP_EXEC);
    fault_seq(1, IM_STOP_EXEC);
    wr(OFS_RUN, 8'h02);
    for (int ch = 0; ch < 2; ch++) begin
      setch(ch, IM_STOP_RPT, 1'b0, 1'b0);
      wait_ph(ch == 0 ? PH_DT0 : PH_DT1);
      j0 = jmp_cnt;
      fault[ch] <= 1'b1;
      repeat (40) @(posedge clk);
      chk(8'(jmp_cnt - j0 > 1), 8'h01);
      chk(8'(ctl.sub_hold[ch]), 8'h00);
      fault[ch] <= 1'b0;
      wt(0, ch, 1'b0, 40);
    end
    wr(OFS_RUN, 8'h01);
    setch(0, IM_RETRIG, 1'b0, 1'b0);
    j0 = jmp_cnt;
    wait_ph(PH_DT1);
    pulse(0, 4);
    chk(8'(jmp_cnt - j0), 8'h00);
    wait_ph(PH_DT0);
    pulse(0, 4);
    chk(8'(jmp_cnt - j0), 8'h01);
    for (int m = 0; m < 16; m++) begin
      if (m inside {1, 2, 3, 8}) continue;
      setch(0, 4'(m), 1'b0, 1'b0);
      j0 = jmp_cnt + rel_cnt;
      wait_ph(PH_DT0);
      pulse(0, 6);
      chk(8'(jmp_cnt + rel_cnt - j0), 8'h00);
    end
    // One-ramp clears the counter, centered ignores retrigger
    for (int rm = 0; rm < 4; rm += 3) begin
      wr(OFS_RUN, 8'(rm));
      for (int ch = 0; ch < 2; ch++) begin
        setch(ch, IM_RETRIG, 1'b0, 1'b0);
        k0 = clr_cnt + jmp_cnt;
        wait_ph(PH_OT1);
        pulse(ch, 4);
        chk(8'(clr_cnt + jmp_cnt - k0), 8'(rm == 0));
      end
    end
    wr(OFS_RUN, 8'h00);
    setch(0, IM_RETRIG, 1'b1, 1'b0);
    k0 = clr_cnt;
    pulse(0, 1 + int'($urandom % 3));
    chk(8'(clr_cnt - k0), 8'h00);
    pulse(0, 10);
    chk(8'(clr_cnt - k0), 8'h01);
    setch(0, IM_RETRIG, 1'b0, 1'b1);
    k0 = clr_cnt;
    fault[0] <= 1'b1;
    @(negedge clk);
    chk(8'(kill), 8'h01);
    repeat (8) @(posedge clk);
    chk(8'(clr_cnt - k0), 8'h01);
    fault[0] <= 1'b0;
    @(negedge clk);
    chk(8'(kill), 8'h00);
    @(posedge clk);
    results();
  end
endmodule
